/* hdl/cpwm_pkg.sv */
// Constants, register map and carrier types of the compare/PWM unit.
// Assumes a 32-bit APB master and separate event and period timer blocks.
//
// Notes on behaviour
// R1: Writing zero to the control register forces the compare output latch low.
// R2: Software keeps the event timer synchronous while compare is in use.
// R3: Mode 1010 sets the event flag on match and leaves the pin alone.
// R4: Mode 1011 match resets the event timer, starts conversion if enabled.
// R5: Trigger fires in the match cycle; timer reset waits for next timer tick.
// R6: The special event trigger never sets the timer overflow flag.
// R7: If the match vanishes before the timer tick, no timer reset happens.
// R8: PWM drives the shared pin; software clears pin direction to enable driver.
// R9: Clearing the control register hands the pin back to the port latch.
// R10: In PWM mode the compare high byte holds duty and is read-only.
// R11: PWM period is (period match + 1) times 4 clocks times prescale.
// R12: After period match: clear timer, set pin unless duty zero, reload duty.
// R13: The period timer postscaler plays no part in the PWM period.
// R14: Duty is compare low byte above control bits 5:4; writable any time.
// R15: New duty takes effect only when the current period ends.
// R16: High time is duty value times one clock times prescale.
// R17: Duty is double-buffered in high byte plus hidden 2-bit latch.
// R18: Time base low bits come from clock phase at 1:1, else prescaler.
// R19: Time base equal to buffered duty clears the PWM output.
// R20: Duty beyond the period never clears the output.
// R21: Resolution is log2 of 4 times (period match + 1); 10 bits at 255.
// R22: In sleep all unit state freezes and the pin holds its level.
// R23: Mode 0000 turns the unit off and resets its internal state.
// R24: Modes 1000 and 1001 set or clear the output on match, set flag.
// R25: Modes 110x give active-high PWM, 111x active-low PWM.
// R26: In compare mode the compare register is checked against the timer every cycle.
// R27: Timer counts, increment strobes and prescale arrive as inputs.
package cpwm_pkg;
  localparam int unsigned CPWM_ADDR_W = 8;
  localparam logic [7:0] CPWM_OFF_CTRL = 8'h00;
  localparam logic [7:0] CPWM_OFF_CMP_LOW = 8'h04;
  localparam logic [7:0] CPWM_OFF_CMP_HIGH = 8'h08;
  localparam logic [7:0] CPWM_OFF_PERIOD = 8'h0C;
  localparam logic [7:0] CPWM_OFF_STATUS = 8'h10;
  localparam logic [5:0] CPWM_CTRL_RESET = 6'h00;
  localparam logic [7:0] CPWM_CMP_RESET = 8'h00;
  localparam logic [7:0] CPWM_PERIOD_RESET = 8'hFF;
  localparam int unsigned CPWM_DUTY_LSB = 4;
  localparam int unsigned CPWM_ST_FLAG = 0;
  localparam int unsigned CPWM_ST_PIN = 1;
  localparam int unsigned CPWM_ST_OWN = 2;
  localparam int unsigned CPWM_ST_PEND = 3;
  localparam logic [3:0] CPWM_MODE_OFF = 4'h0;
  localparam logic [3:0] CPWM_MODE_SET = 4'h8;
  localparam logic [3:0] CPWM_MODE_CLR = 4'h9;
  localparam logic [3:0] CPWM_MODE_SWI = 4'hA;
  localparam logic [3:0] CPWM_MODE_SPEV = 4'hB;
  localparam logic [1:0] CPWM_GRP_CMP = 2'h2;
  localparam logic [1:0] CPWM_GRP_PWM = 2'h3;
  localparam logic [1:0] CPWM_PS_1 = 2'h0;
  localparam logic [1:0] CPWM_PS_4 = 2'h1;
  localparam int unsigned CPWM_CLK_PER_TICK = 4;
  localparam int unsigned CPWM_PHASE_W = $clog2(CPWM_CLK_PER_TICK);
  localparam logic [CPWM_PHASE_W-1:0] CPWM_PHASE_ONE = 2'h1;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } cpwm_apb_s;

  typedef struct packed {
    logic [15:0] event_count;
    logic event_tick;
    logic [7:0] period_count;
    logic period_tick;
    logic [1:0] prescale;
    logic [3:0] prescale_count;
  } cpwm_timer_s;
endpackage : cpwm_pkg

/* hdl/cpwm_unit.sv */
// Compare and PWM output unit with its APB register file.
// Assumes timer blocks supply counts and strobes in the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module cpwm_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire cpwm_pkg::cpwm_apb_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer blocks (see R27)
  input wire cpwm_pkg::cpwm_timer_s timer_in,
  output logic event_timer_reset,
  output logic period_timer_clear,
  // Converter
  input wire logic adc_enabled,
  output logic special_event,
  output logic conversion_start,
  // System and port
  input wire logic sleep_mode,
  input wire logic port_data_latch,
  input wire logic pin_direction_bit,
  output logic unit_output_pin,
  output logic unit_output_pin_oe,
  output logic pin_owned,
  output logic unit_event_flag
);
  import cpwm_pkg::*;

  function automatic logic cpwm_mapped(input logic [7:0] a);
    cpwm_mapped = (a == CPWM_OFF_CTRL) || (a == CPWM_OFF_CMP_LOW) ||
                  (a == CPWM_OFF_CMP_HIGH) || (a == CPWM_OFF_PERIOD) ||
                  (a == CPWM_OFF_STATUS);
  endfunction : cpwm_mapped

  logic [5:0] unit_control_reg;
  logic [7:0] compare_low_byte;
  logic [7:0] compare_high_byte;
  logic [7:0] period_match_value;
  logic cmp_latch;
  logic pwm_level;
  logic [1:0] duty_low_latch;
  logic reset_pending;
  logic match_q;
  logic [CPWM_PHASE_W-1:0] phase;
  logic [5:0] next_unit_control_reg;
  logic [7:0] next_compare_low_byte;
  logic [7:0] next_compare_high_byte;
  logic [7:0] next_period_match_value;
  logic next_unit_event_flag;
  logic next_cmp_latch;
  logic next_pwm_level;
  logic [1:0] next_duty_low_latch;
  logic next_reset_pending;
  logic next_match_q;
  logic [CPWM_PHASE_W-1:0] next_phase;
  logic [31:0] next_prdata;

  logic [3:0] mode_select;
  logic [1:0] duty_low_bits;
  logic is_cmp;
  logic is_pwm;
  logic cmp_match;
  logic match_rise;
  logic period_end;
  logic [1:0] tb_low;
  logic [9:0] time_base;
  logic [9:0] duty_buf;
  logic [9:0] duty_new;
  logic duty_hit;
  logic pwm_out;
  logic wr_en;
  logic setup_rd;
  logic [7:0] status_byte;

  assign mode_select = unit_control_reg[3:0];
  assign duty_low_bits = unit_control_reg[5:4];
  assign is_cmp = mode_select[3:2] == CPWM_GRP_CMP;
  assign is_pwm = mode_select[3:2] == CPWM_GRP_PWM;
  // Compare runs every cycle on the event timer value (see R26)
  assign cmp_match = is_cmp && (timer_in.event_count == {compare_high_byte, compare_low_byte});
  assign match_rise = cmp_match && !match_q;
  // Trigger in the cycle the match appears (see R5) (see R4)
  assign special_event = match_rise && (mode_select == CPWM_MODE_SPEV);
  assign conversion_start = special_event && adc_enabled; // see R4
  // Timer reset waits for the next timer tick, and only if still matching (see R5) (see R7)
  // Separate strobe, so the timer block never counts it as overflow (see R6)
  assign event_timer_reset = reset_pending && timer_in.event_tick && cmp_match && !sleep_mode;
  // Postscaler is not an input: period depends on match and prescale only (see R13)
  // One period is (match + 1) ticks of 4 clocks times prescale (see R11) (see R21)
  assign period_end = is_pwm && timer_in.period_tick && !sleep_mode &&
                      (timer_in.period_count == period_match_value);
  assign period_timer_clear = period_end; // see R12

  // Low time-base bits: clock phase at 1:1, prescaler bits otherwise (see R18)
  always_comb begin
    case (timer_in.prescale)
      CPWM_PS_1: tb_low = phase;
      CPWM_PS_4: tb_low = timer_in.prescale_count[1:0];
      default: tb_low = timer_in.prescale_count[3:2];
    endcase
  end

  assign time_base = {timer_in.period_count, tb_low};
  assign duty_buf = {compare_high_byte, duty_low_latch}; // see R17
  assign duty_new = {compare_low_byte, duty_low_bits}; // see R14
  // Drop the output in the match cycle itself, so high time equals the duty count (see R16)
  // Cost: the PWM output is gated combinationally by the time base compare
  assign duty_hit = is_pwm && !period_end && (time_base == duty_buf);
  assign pwm_out = pwm_level && !duty_hit;

  // Pin ownership: set/clear compare and both PWM polarities (see R3) (see R4) (see R9)
  assign pin_owned = (mode_select == CPWM_MODE_SET) || (mode_select == CPWM_MODE_CLR) || is_pwm;
  // Output polarity follows mode bit 1 in PWM (see R25) (see R8)
  assign unit_output_pin = !pin_owned ? port_data_latch :
                           is_pwm ? (pwm_out ^ mode_select[1]) : cmp_latch;
  // Driver enabled only when software clears the direction bit (see R8)
  assign unit_output_pin_oe = !pin_direction_bit;

  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign pready = 1'b1;
  assign pslverr = apb_req.psel && apb_req.penable && !cpwm_mapped(apb_req.paddr);
  assign status_byte = {4'h0, reset_pending, pin_owned, unit_output_pin, unit_event_flag};

  // Unit behaviour
  always_comb begin
    next_cmp_latch = cmp_latch;
    next_pwm_level = pwm_level;
    next_duty_low_latch = duty_low_latch;
    next_reset_pending = reset_pending;
    next_match_q = match_q;
    next_phase = phase;
    next_unit_event_flag = unit_event_flag;
    next_compare_high_byte = compare_high_byte;
    if (sleep_mode) begin
      // Everything holds, pin keeps its level (see R22)
      next_phase = phase;
    end else if (mode_select == CPWM_MODE_OFF) begin
      // Off clears latches, pending reset, match history and phase; the event flag holds (see R23)
      next_cmp_latch = 1'b0;
      next_pwm_level = 1'b0;
      next_duty_low_latch = 2'h0;
      next_reset_pending = 1'b0;
      next_match_q = 1'b0;
      next_phase = '0;
    end else begin
      next_match_q = cmp_match;
      // Restart on each period tick, so the time base counts up in order (see R18)
      if (timer_in.period_tick) begin
        next_phase = '0;
      end else begin
        next_phase = phase + CPWM_PHASE_ONE;
      end
      if (match_rise) begin
        // Every compare mode raises the flag (see R3) (see R24)
        next_unit_event_flag = 1'b1;
        if (mode_select == CPWM_MODE_SET) begin
          next_cmp_latch = 1'b1; // see R24
        end else if (mode_select == CPWM_MODE_CLR) begin
          next_cmp_latch = 1'b0; // see R24
        end
      end
      if (special_event) begin
        next_reset_pending = 1'b1;
      end else if (reset_pending && timer_in.event_tick) begin
        // Consumed by the tick, or dropped if the match went away (see R7)
        next_reset_pending = 1'b0;
      end
      if (period_end) begin
        // Reload buffer and start a new high phase unless the new duty is zero (see R12) (see R15)
        next_compare_high_byte = compare_low_byte;
        next_duty_low_latch = duty_low_bits;
        next_pwm_level = duty_new != 10'h000;
      end else if (duty_hit) begin
        // Duty past the period never matches, so output stays (see R19) (see R20) (see R16)
        next_pwm_level = 1'b0;
      end
    end
    if (!is_pwm) begin
      next_pwm_level = next_pwm_level & is_pwm;
    end
  end

  // Register writes and reads
  always_comb begin
    next_unit_control_reg = unit_control_reg;
    next_compare_low_byte = compare_low_byte;
    next_period_match_value = period_match_value;
    next_prdata = prdata;
    if (wr_en) begin
      case (apb_req.paddr)
        CPWM_OFF_CTRL: begin
          next_unit_control_reg = apb_req.pwdata[5:0];
        end
        CPWM_OFF_CMP_LOW: begin
          next_compare_low_byte = apb_req.pwdata[7:0]; // see R14
        end
        CPWM_OFF_PERIOD: begin
          next_period_match_value = apb_req.pwdata[7:0];
        end
        default: begin
          next_unit_control_reg = unit_control_reg;
        end
      endcase
    end
    if (setup_rd) begin
      case (apb_req.paddr)
        CPWM_OFF_CTRL: begin
          next_prdata = {26'h0, unit_control_reg};
        end
        CPWM_OFF_CMP_LOW: begin
          next_prdata = {24'h0, compare_low_byte};
        end
        CPWM_OFF_CMP_HIGH: begin
          // Buffered duty while PWM runs (see R10)
          next_prdata = {24'h0, compare_high_byte};
        end
        CPWM_OFF_PERIOD: begin
          next_prdata = {24'h0, period_match_value};
        end
        CPWM_OFF_STATUS: begin
          next_prdata = {24'h0, status_byte};
        end
        default: begin
          // Unmapped reads return zero
          next_prdata = 32'h0;
        end
      endcase
    end
  end

  logic [5:0] wr_ctrl_value;
  logic wr_ctrl;
  logic wr_high;
  logic clr_flag;
  logic [7:0] fin_compare_high_byte;
  logic fin_cmp_latch;
  logic fin_flag;

  assign wr_ctrl = wr_en && (apb_req.paddr == CPWM_OFF_CTRL);
  assign wr_ctrl_value = apb_req.pwdata[5:0];
  // High byte is read-only while PWM runs (see R10)
  assign wr_high = wr_en && (apb_req.paddr == CPWM_OFF_CMP_HIGH) && !is_pwm;
  assign clr_flag = wr_en && (apb_req.paddr == CPWM_OFF_STATUS) && apb_req.pwdata[CPWM_ST_FLAG];
  assign fin_compare_high_byte = wr_high ? apb_req.pwdata[7:0] : next_compare_high_byte;
  // Zero written to control drops the compare latch at once (see R1)
  assign fin_cmp_latch = (wr_ctrl && wr_ctrl_value == CPWM_CTRL_RESET) ? 1'b0 : next_cmp_latch;
  // Hardware set wins over a same-cycle clear
  assign fin_flag = (unit_event_flag && !clr_flag) || (next_unit_event_flag && !unit_event_flag) ||
                    (unit_event_flag && match_rise && !sleep_mode && mode_select != CPWM_MODE_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_control_reg <= CPWM_CTRL_RESET;
      compare_low_byte <= CPWM_CMP_RESET;
      compare_high_byte <= CPWM_CMP_RESET;
      period_match_value <= CPWM_PERIOD_RESET;
      unit_event_flag <= 1'b0;
      cmp_latch <= 1'b0;
      pwm_level <= 1'b0;
      duty_low_latch <= 2'h0;
      reset_pending <= 1'b0;
      match_q <= 1'b0;
      phase <= '0;
      prdata <= 32'h0;
    end else begin
      unit_control_reg <= next_unit_control_reg;
      compare_low_byte <= next_compare_low_byte;
      compare_high_byte <= fin_compare_high_byte;
      period_match_value <= next_period_match_value;
      unit_event_flag <= fin_flag;
      cmp_latch <= fin_cmp_latch;
      pwm_level <= next_pwm_level;
      duty_low_latch <= next_duty_low_latch;
      reset_pending <= next_reset_pending;
      match_q <= next_match_q;
      phase <= next_phase;
      prdata <= next_prdata;
    end
  end
endmodule : cpwm_unit
`default_nettype wire

/* testbench/cpwm_load.sv */
// External load on the unit pin: measures high time and period.
// Assumes the pin is only meaningful while its driver is enabled.
`timescale 1ns/1ps
`default_nettype none
module cpwm_load (
  // Clock and pin
  input wire logic pclk,
  input wire logic pin,
  input wire logic oe,
  // Measurements in clocks
  output int hi_len,
  output int per_len,
  output int run
);
  logic last = 1'b0;
  int cnt = 0;
  // Pin seen only with the driver on
  always @(posedge pclk) begin
    if (oe && pin !== last) begin
      run <= 1;
      if (pin) begin
        per_len <= cnt;
        cnt <= 1;
      end else begin
        hi_len <= cnt;
        cnt <= cnt + 1;
      end
    end else begin
      run <= run + 1;
      cnt <= cnt + 1;
    end
    last <= oe ? pin : last;
  end
endmodule : cpwm_load
`default_nettype wire

/* testbench/cpwm_unit_props.sv */
// Port-level checks of the compare/PWM unit.
// Assumes one pclk domain; register writes are mirrored from the APB port.
`timescale 1ns/1ps
`default_nettype none
module cpwm_unit_props (
  // Clock, reset, APB
  input wire logic pclk,
  input wire logic presetn,
  input wire cpwm_pkg::cpwm_apb_s apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timers and converter
  input wire cpwm_pkg::cpwm_timer_s timer_in,
  input wire logic event_timer_reset,
  input wire logic period_timer_clear,
  input wire logic adc_enabled,
  input wire logic special_event,
  input wire logic conversion_start,
  // System and port
  input wire logic sleep_mode,
  input wire logic port_data_latch,
  input wire logic pin_direction_bit,
  input wire logic unit_output_pin,
  input wire logic unit_output_pin_oe,
  input wire logic pin_owned,
  input wire logic unit_event_flag
);
  import cpwm_pkg::*;
  logic [5:0] ctrl, next_ctrl;
  logic [15:0] cmp, next_cmp;
  logic [7:0] per, next_per;
  logic wr, match;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign match = ctrl[3:2] == CPWM_GRP_CMP && timer_in.event_count == cmp;
  // High byte reload in PWM is not mirrored; compare checks follow fresh writes
  always_comb begin
    next_ctrl = ctrl;
    next_cmp = cmp;
    next_per = per;
    if (wr && apb_req.paddr == CPWM_OFF_CTRL) next_ctrl = apb_req.pwdata[5:0];
    if (wr && apb_req.paddr == CPWM_OFF_CMP_LOW) next_cmp[7:0] = apb_req.pwdata[7:0];
    if (wr && apb_req.paddr == CPWM_OFF_CMP_HIGH && ctrl[3:2] != CPWM_GRP_PWM) next_cmp[15:8] = apb_req.pwdata[7:0];
    if (wr && apb_req.paddr == CPWM_OFF_PERIOD) next_per = apb_req.pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CPWM_CTRL_RESET;
      cmp <= 16'h0000;
      per <= CPWM_PERIOD_RESET;
    end else begin
      ctrl <= next_ctrl;
      cmp <= next_cmp;
      per <= next_per;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rise;
    !match ##1 match && !sleep_mode;
  endsequence
  property p_flag;
    s_rise |=> unit_event_flag;
  endproperty
  property p_latch;
    s_rise ##0 ctrl[3:1] == 3'h4 |=> unit_output_pin == !ctrl[0];
  endproperty
  property p_nopin;
    ctrl[3:1] == 3'h5 |-> !pin_owned;
  endproperty
  property p_off;
    ctrl[3:0] == CPWM_MODE_OFF |-> !pin_owned && unit_output_pin == port_data_latch;
  endproperty
  property p_sev;
    special_event |-> match && ctrl[3:0] == CPWM_MODE_SPEV;
  endproperty
  property p_sev_rise;
    s_rise ##0 ctrl[3:0] == CPWM_MODE_SPEV |-> special_event;
  endproperty
  property p_conv;
    conversion_start == (special_event && adc_enabled);
  endproperty
  property p_etr;
    event_timer_reset |-> timer_in.event_tick && match && ctrl[3:0] == CPWM_MODE_SPEV;
  endproperty
  property p_oe;
    unit_output_pin_oe == !pin_direction_bit;
  endproperty
  property p_pclr;
    timer_in.period_tick && timer_in.period_count == per && ctrl[3:2] == CPWM_GRP_PWM && !sleep_mode
      |-> period_timer_clear;
  endproperty
  property p_sleep;
    sleep_mode && $past(sleep_mode) && pin_owned && $stable(ctrl) |-> $stable(unit_output_pin);
  endproperty
  a_flag: assert property (p_flag) else $error("event flag not set on match");
  a_latch: assert property (p_latch) else $error("compare latch wrong after match");
  a_nopin: assert property (p_nopin) else $error("pin taken in flag-only mode");
  a_off: assert property (p_off) else $error("pin not released when off");
  a_sev: assert property (p_sev) else $error("trigger without match");
  a_sev_rise: assert property (p_sev_rise) else $error("trigger late on match");
  a_conv: assert property (p_conv) else $error("conversion start mismatch");
  a_etr: assert property (p_etr) else $error("timer reset without live match");
  a_oe: assert property (p_oe) else $error("driver enable wrong");
  a_pclr: assert property (p_pclr) else $error("period timer not cleared");
  a_sleep: assert property (p_sleep) else $error("pin moved in sleep");
endmodule : cpwm_unit_props
bind cpwm_unit cpwm_unit_props u_props (.pclk, .presetn, .apb_req, .prdata, .pready, .pslverr, .timer_in,
  .event_timer_reset, .period_timer_clear, .adc_enabled, .special_event, .conversion_start, .sleep_mode,
  .port_data_latch, .pin_direction_bit, .unit_output_pin, .unit_output_pin_oe, .pin_owned, .unit_event_flag);
`default_nettype wire

/* testbench/cpwm_unit_test.sv */
// Self-checking bench for the compare/PWM unit.
// Drives APB, both timer feeds and the port; a load model watches the pin.
`timescale 1ns/1ps
`default_nettype none
module cpwm_unit_test;
  import cpwm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  cpwm_apb_s req = '0;
  cpwm_timer_s tmr;
  logic [15:0] ev_cnt = 16'h0000;
  logic ev_tick = 1'b0, pt_tick = 1'b0;
  logic [7:0] pt_cnt = 8'h00, pr_m = 8'hFF;
  logic adc_en = 1'b1, sleep = 1'b0, pdl = 1'b1, dir = 1'b1, err;
  logic pready, pslverr, etr, pclr, sev, conv, pin, oe, owned, flag;
  logic [31:0] prdata, rd, seed = 32'h2256;
  logic [1:0] ph = 2'h0;
  logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
  logic [31:0] rv[5] = '{32'h0, 32'h0, 32'h0, 32'hFF, 32'h0};
  int n_mismatch = 0, n_checks = 0, n_etr = 0, n_pclr = 0, hi_len, per_len, run;
  cpwm_unit DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_in(tmr), .event_timer_reset(etr), .period_timer_clear(pclr), .adc_enabled(adc_en),
    .special_event(sev), .conversion_start(conv), .sleep_mode(sleep), .port_data_latch(pdl),
    .pin_direction_bit(dir), .unit_output_pin(pin), .unit_output_pin_oe(oe), .pin_owned(owned),
    .unit_event_flag(flag));
  cpwm_load LOAD (.pclk(pclk), .pin(pin), .oe(oe), .hi_len(hi_len), .per_len(per_len), .run(run));
  assign tmr = '{event_count: ev_cnt, event_tick: ev_tick, period_count: pt_cnt, period_tick: pt_tick,
                 prescale: CPWM_PS_1, prescale_count: 4'h0};
  initial begin
    forever #20 pclk = ~pclk;
  end
  // Period timer: one tick every 4 clocks, frozen in sleep
  always @(posedge pclk) begin
    n_etr <= n_etr + int'(etr);
    n_pclr <= n_pclr + int'(pclr);
    ph <= sleep ? ph : ph + 2'h1;
    pt_tick <= !sleep && ph == 2'h3;
    // Timer wraps at its period value on its own, and never moves in sleep
    if (pt_tick && !sleep) pt_cnt <= (pclr || pt_cnt >= pr_m) ? 8'h00 : pt_cnt + 8'h01;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic ev(input logic [15:0] v);
    @(posedge pclk);
    ev_cnt <= v;
  endtask : ev
  task automatic tick();
    @(posedge pclk);
    ev_tick <= 1'b1;
    @(posedge pclk);
    ev_tick <= 1'b0;
  endtask : tick
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    logic [15:0] cv;
    int duty, exp_etr, p0;
    exp_etr = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
      chk(32'(err), 32'(ra[i] == 8'h14));
    end
    for (int m = 8; m < 13; m++) begin
      cv = 16'(xs());
      pdl <= seed[3];
      adc_en <= seed[4];
      ev(cv - 16'h0005);
      apb(1'b1, CPWM_OFF_CMP_LOW, {24'h0, cv[7:0]});
      apb(1'b1, CPWM_OFF_CMP_HIGH, {24'h0, cv[15:8]});
      apb(1'b1, CPWM_OFF_CTRL, 32'(m == 12 ? 11 : m));
      apb(1'b1, CPWM_OFF_STATUS, 32'h1);
      @(negedge pclk);
      chk(32'(flag), 32'h0);
      ev(cv);
      if (m == 12) apb(1'b1, CPWM_OFF_CMP_LOW, {24'h0, ~cv[7:0]});
      repeat (3) @(negedge pclk);
      chk(32'(flag), 32'h1);
      chk(32'(pin), m < 10 ? 32'(m == 8) : 32'(pdl));
      tick();
      exp_etr += int'(m == 11);
      @(negedge pclk);
      chk(n_etr, exp_etr);
      if (m == 8) begin
        apb(1'b1, CPWM_OFF_CTRL, 32'h0);
        @(negedge pclk);
        chk({owned, pin}, {1'b0, pdl});
      end
    end
    apb(1'b1, CPWM_OFF_CTRL, 32'h0);
    apb(1'b1, CPWM_OFF_PERIOD, 32'h3);
    dir <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      duty = i == 0 ? 0 : i == 3 ? 17 + int'(xs() % 8) : i == 4 ? 5 : 1 + int'(xs() % 15);
      if (i == 4) apb(1'b1, CPWM_OFF_CMP_HIGH, 32'hA5);
      if (i == 4) apb(1'b0, CPWM_OFF_CMP_HIGH, 32'h0);
      if (i == 4) chk(rd, 32'(duty_prev(i, duty)));
      apb(1'b1, CPWM_OFF_CMP_LOW, 32'(duty >> 2));
      apb(1'b1, CPWM_OFF_CTRL, 32'(((duty & 3) << 4) | (i == 4 ? 14 : 12)));
      p0 = n_pclr;
      repeat (40) @(negedge pclk);
      if (i == 0 || i == 3) chk({pin, 31'(run >= 20)}, {i == 3, 31'h1});
      else chk(hi_len, i == 4 ? 16 - duty : duty);
      chk(i == 0 ? 32'(n_pclr - p0 >= 2) : per_len, i == 0 ? 1 : 16);
    end
    // Enter sleep early in a high phase, well away from the next edge of the pin
    for (int k = 0; k < 40 && !(pin === 1'b1 && run < 4); k++) @(negedge pclk);
    @(posedge pclk);
    sleep <= 1'b1;
    repeat (30) @(negedge pclk);
    chk({pin, 31'(run >= 29)}, {1'b1, 31'h1});
    sleep <= 1'b0;
    end_sim();
  end
  // Latched high byte is the low byte of the previous duty step
  logic [7:0] last_hi = 8'h00;
  function automatic logic [7:0] duty_prev(input int i, input int d);
    return last_hi;
  endfunction : duty_prev
  always @(posedge pclk) begin
    if (req.psel && req.penable && req.pwrite && req.paddr == CPWM_OFF_CMP_LOW) last_hi <= req.pwdata[7:0];
    if (req.psel && req.penable && req.pwrite && req.paddr == CPWM_OFF_PERIOD) pr_m <= req.pwdata[7:0];
  end
endmodule : cpwm_unit_test
`default_nettype wire
